// *** logic/uidc_top.sv ***
// uart channel interrupt enable, priority, status and divisor mode control
// Contract
// RULE_01 - divisor registers visible only while divisor-select bit is set
// RULE_02 - direction pin high on transmit, low on receive; polarity bit inverts
// RULE_03 - multidrop bit selects 9-bit address operation
// RULE_04 - parity check bit drops flow characters with parity errors
// RULE_05 - infrared pulse is 3/16 bit, or 1/4 bit in fast mode
// RULE_06 - receive available follows fifo level versus trigger
// RULE_07 - data ready set when fifo holds a character, cleared when empty
// RULE_08 - line status bits report overrun, top errors, transmit empties, fifo error
// RULE_09 - enabled rising edge of clear-to-send or request-to-send interrupts
// RULE_10 - enable bit 5 gates the received xoff interrupt; bit 4 reserved
// RULE_11 - enable bit 3 raises modem interrupt on any delta bit
// RULE_12 - line error interrupts on receipt and again at fifo top
// RULE_13 - error bits 4 to 1 describe only the top character
// RULE_14 - transmit ready on empty holding, trigger fall, or fifo empty
// RULE_15 - enable bit 0 raises receive ready on data or trigger
// RULE_16 - status shows only the highest pending source until serviced
// RULE_17 - fixed status codes for seven levels, 0x01 when none
// RULE_18 - timeout after four characters plus twelve bits below trigger
// RULE_19 - auto flow pin rises flag a flow-pin change, pair chosen by modem bit 2
// RULE_20 - wake indication set on sleep exit, cleared by summary read
// RULE_21 - each source cleared by its own register access
// RULE_22 - status bits 7:6 show fifo enable, bit 0 low while pending
// RULE_23 - events stay pending until cleared; interrupt when enabled one pending
// RULE_24 - multidrop forces parity 0 and reports address bytes as parity errors
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/100ps
module uidc_top #(
	parameter int LVL_W = uidc_pkg::LVL_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// register port
	input wire logic [3:0] addr,
	input wire logic [7:0] wr_data,
	input wire logic wr_stb,
	input wire logic rd_stb,
	output logic [7:0] rd_data,
	// receive path
	input wire logic [LVL_W-1:0] rx_level,
	input wire logic [LVL_W-1:0] rx_trig,
	input wire logic rx_push,
	input wire logic [3:0] rx_push_err,
	input wire logic [3:0] rx_top_err,
	input wire logic rx_fifo_err,
	input wire logic [7:0] rx_char,
	output logic rx_pop,
	// transmit path
	input wire logic [LVL_W-1:0] tx_level,
	input wire logic [LVL_W-1:0] tx_trig,
	input wire logic tx_shift_empty,
	input wire logic tx_active,
	output logic tx_push,
	output logic [7:0] tx_data,
	// modem and flow pins
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic rts_n,
	input wire logic dtr_n,
	input wire logic [3:0] msr_delta,
	input wire logic [3:0] msr_state,
	input wire logic flow_char,
	input wire logic flow_char_xoff,
	input wire logic flow_par_err,
	input wire logic special_char,
	output logic flow_char_ok,
	// timing and power
	input wire logic bit_tick,
	input wire logic sleep_exit,
	// mode and divisor outputs
	output logic [7:0] div_low,
	output logic [7:0] div_high,
	output logic [3:0] div_frac,
	output logic dir_pin,
	output logic multidrop_en,
	output logic force_parity_zero,
	output logic [2:0] ir_pulse_16ths,
	output logic [7:0] line_format,
	output logic [7:0] modem_ctrl,
	output logic [7:0] fifo_ctrl,
	output logic [7:0] enh_feat,
	output logic [7:0] feat_ctrl,
	// interrupt and wake
	output logic irq,
	output logic wake_ind
);
	import uidc_pkg::*;

	uidc_ev_if ev ();

	logic [7:0] ier_q;
	logic [7:0] dfm_q;
	logic ls_pend_q;
	logic tx_pend_q;
	logic ms_pend_q;
	logic xsp_pend_q;
	logic flow_pend_q;
	logic top_err_q;
	logic tx_below_q;
	logic tx_empty_q;
	logic pin_in_q;
	logic pin_out_q;
	logic [7:0] rd_d;
	logic dlab;
	logic fifo_en;
	logic rhr_rd;
	logic thr_wr;
	logic isr_rd;
	logic lsr_rd;
	logic msr_rd;
	logic sum_rd;
	logic rx_hit;
	logic ls_set;
	logic tx_below;
	logic tx_empty;
	logic tx_set;
	logic xsp_set;
	logic pin_in;
	logic pin_out;
	logic flow_set;
	logic enh;

	// access decode; the divisor latch shadows data, enable and status
	assign dlab = line_format[LFR_DLAB]; // RULE_01
	assign fifo_en = fifo_ctrl[FCR_FEN];
	assign enh = enh_feat[EFR_ENH];
	assign rhr_rd = rd_stb && addr == A_DATA && !dlab;
	assign thr_wr = wr_stb && addr == A_DATA && !dlab;
	assign isr_rd = rd_stb && addr == A_ISR && !dlab;
	assign lsr_rd = rd_stb && addr == A_LSR;
	assign msr_rd = rd_stb && addr == A_MSR;
	assign sum_rd = rd_stb && addr == A_SUM;

	// configuration registers written by software
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_low <= RST_REG;
			div_high <= RST_REG;
			dfm_q <= RST_REG;
			ier_q <= RST_REG;
			line_format <= RST_REG;
			modem_ctrl <= RST_REG;
			enh_feat <= RST_REG;
			feat_ctrl <= RST_REG;
		end else if (wr_stb) begin
			case (addr)
				A_DATA: if (dlab) div_low <= wr_data; // RULE_01
				A_IEN: begin
					if (dlab) begin
						div_high <= wr_data; // RULE_01
					end else begin
						ier_q <= wr_data & 8'hEF; // RULE_10
					end
				end
				A_ISR: if (dlab) dfm_q <= wr_data; // RULE_01
				A_LFR: line_format <= wr_data;
				A_MCR: modem_ctrl <= wr_data;
				A_FEATURE_CONTROL_REG: feat_ctrl <= wr_data;
				A_EFR: enh_feat <= wr_data;
				default: ;
			endcase
		end
	end

	// fifo control is write only; reset bits last one cycle, bit 0 gates the rest
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fifo_ctrl <= RST_REG;
		end else if (wr_stb && addr == A_ISR && !dlab) begin
			fifo_ctrl <= wr_data[FCR_FEN] ? wr_data : RST_REG;
		end else begin
			fifo_ctrl <= fifo_ctrl & 8'hF9;
		end
	end

	// mode outputs decoded from the fraction/mode register
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_frac <= 4'h0;
			dir_pin <= 1'b0;
			multidrop_en <= 1'b0;
			force_parity_zero <= 1'b0;
			ir_pulse_16ths <= IR_W_SLOW;
		end else begin
			div_frac <= dfm_q[3:0];
			dir_pin <= tx_active ^ dfm_q[DFM_POL]; // RULE_02
			multidrop_en <= dfm_q[DFM_MDROP]; // RULE_03
			force_parity_zero <= dfm_q[DFM_MDROP]; // RULE_24
			ir_pulse_16ths <= dfm_q[DFM_FIR] ? IR_W_FAST : IR_W_SLOW; // RULE_05
		end
	end

	// flow characters with parity errors are dropped only when checking is on
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			flow_char_ok <= 1'b0;
		end else begin
			flow_char_ok <= flow_char && !(dfm_q[DFM_PCHK] && flow_par_err); // RULE_04
		end
	end

	// data strobes towards the fifos
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rx_pop <= 1'b0;
			tx_push <= 1'b0;
			tx_data <= 8'h00;
		end else begin
			rx_pop <= rhr_rd;
			tx_push <= thr_wr;
			if (thr_wr) tx_data <= wr_data;
		end
	end

	// receive ready is a live level: it drops as soon as the fifo falls below
	assign rx_hit = fifo_en ? (rx_level >= rx_trig) : (rx_level != '0); // RULE_06 RULE_15

	// line errors flag on receipt and again when an errored byte reaches the top
	assign ls_set = (rx_push && |rx_push_err) || (|rx_top_err && !top_err_q); // RULE_12
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			top_err_q <= 1'b0;
			ls_pend_q <= 1'b0;
		end else begin
			top_err_q <= |rx_top_err;
			if (ls_set) begin
				ls_pend_q <= 1'b1; // RULE_23
			end else if (lsr_rd) begin
				ls_pend_q <= 1'b0; // RULE_21
			end
		end
	end

	// transmit ready: fall below trigger, then empty; half duplex waits for shift empty
	assign tx_below = tx_level < tx_trig;
	assign tx_empty = (tx_level == '0) && (!feat_ctrl[FEATURE_CONTROL_REG_A485] || tx_shift_empty);
	assign tx_set = fifo_en ? ((tx_below && !tx_below_q) || (tx_empty && !tx_empty_q)) :
		(tx_empty && !tx_empty_q); // RULE_14
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			tx_below_q <= 1'b1;
			tx_empty_q <= 1'b1;
			tx_pend_q <= 1'b0;
		end else begin
			tx_below_q <= tx_below;
			tx_empty_q <= tx_empty;
			if (tx_set) begin
				tx_pend_q <= 1'b1;
			end else if (thr_wr || (isr_rd && ev.sel == SRC_TX)) begin
				tx_pend_q <= 1'b0; // RULE_21
			end
		end
	end

	// modem deltas, xoff/special and wake are sticky until their clearing access
	assign xsp_set = (flow_char && flow_char_xoff && !(dfm_q[DFM_PCHK] && flow_par_err)) ||
		special_char; // RULE_10 RULE_04
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ms_pend_q <= 1'b0;
			xsp_pend_q <= 1'b0;
			wake_ind <= 1'b0;
		end else begin
			if (|msr_delta) begin
				ms_pend_q <= 1'b1; // RULE_11
			end else if (msr_rd) begin
				ms_pend_q <= 1'b0; // RULE_21
			end
			if (xsp_set) begin
				xsp_pend_q <= 1'b1; // RULE_10
			end else if (isr_rd && ev.sel == SRC_XSP) begin
				xsp_pend_q <= 1'b0; // RULE_21
			end
			if (sleep_exit) begin
				wake_ind <= 1'b1; // RULE_20
			end else if (sum_rd) begin
				wake_ind <= 1'b0; // RULE_20
			end
		end
	end

	// flow pin rising edges; modem bit 2 picks the dsr/dtr pair over cts/rts
	assign pin_in = modem_ctrl[MCR_PSEL] ? dsr_n : cts_n;
	assign pin_out = modem_ctrl[MCR_PSEL] ? dtr_n : rts_n;
	assign flow_set = (pin_in && !pin_in_q && (enh_feat[EFR_ACTS] || ier_q[IEN_CTS])) ||
		(pin_out && !pin_out_q && (enh_feat[EFR_ARTS] || ier_q[IEN_RTS])); // RULE_09 RULE_19
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_in_q <= 1'b1;
			pin_out_q <= 1'b1;
			flow_pend_q <= 1'b0;
		end else begin
			pin_in_q <= pin_in;
			pin_out_q <= pin_out;
			if (flow_set) begin
				flow_pend_q <= 1'b1;
			end else if (msr_rd) begin
				flow_pend_q <= 1'b0; // RULE_21
			end
		end
	end

	// timeout runs while data waits below the trigger in fifo mode
	assign ev.arm = fifo_en && rx_level != '0 && rx_level < rx_trig; // RULE_18
	assign ev.tick = bit_tick;
	assign ev.clr = rx_push || rhr_rd; // RULE_21
	assign ev.limit = tmo_limit(line_format[1:0]);

	uidc_rx_timeout u_tmo (
		.clk(clk),
		.sys_rst(sys_rst),
		.ev(ev.tmo)
	);

	// mask pending events with their enables, ranked by index
	assign ev.act[SRC_LS] = ls_pend_q && ier_q[IEN_LS];
	assign ev.act[SRC_RX] = rx_hit && ier_q[IEN_RX]; // RULE_15
	assign ev.act[SRC_TMO] = ev.fire && ier_q[IEN_RX];
	assign ev.act[SRC_TX] = tx_pend_q && ier_q[IEN_TX];
	assign ev.act[SRC_MS] = ms_pend_q && ier_q[IEN_MS]; // RULE_11
	assign ev.act[SRC_XSP] = xsp_pend_q && enh && ier_q[IEN_XOFF]; // RULE_10
	assign ev.act[SRC_FLOW] = flow_pend_q && enh && |ier_q[IEN_CTS:IEN_RTS]; // RULE_09

	uidc_prio u_prio (
		.clk(clk),
		.sys_rst(sys_rst),
		.ev(ev.pri)
	);

	// channel interrupt while any enabled event is pending
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |ev.act; // RULE_23
		end
	end

	// read data mux; error bits describe only the top byte
	always_comb begin
		rd_d = 8'h00;
		case (addr)
			A_DATA: rd_d = dlab ? div_low : rx_char;
			A_IEN: rd_d = dlab ? div_high : ier_q;
			A_ISR: rd_d = dlab ? dfm_q : {fifo_en, fifo_en, ev.code}; // RULE_22 RULE_17
			A_LFR: rd_d = line_format;
			A_MCR: rd_d = modem_ctrl;
			A_LSR: rd_d = {rx_fifo_err, (tx_level == '0) && tx_shift_empty,
				tx_level == '0, rx_top_err, rx_level != '0}; // RULE_07 RULE_08 RULE_13
			A_MSR: rd_d = {msr_state, msr_delta};
			A_FEATURE_CONTROL_REG: rd_d = feat_ctrl;
			A_EFR: rd_d = enh_feat;
			A_SUM: rd_d = {7'h00, wake_ind};
			default: rd_d = 8'h00;
		endcase
	end

	// read data stand in the cycle after the strobe only
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rd_data <= 8'h00;
		end else begin
			rd_data <= rd_stb ? rd_d : 8'h00;
		end
	end

	chk_div_low_window: assert property (@(posedge clk) disable iff (sys_rst) // RULE_01
		(wr_stb && addr == A_DATA && dlab) |=> (div_low == $past(wr_data) && !tx_push))
		else $error("divisor low not written under divisor select");
	chk_dir_pin_level: assert property (@(posedge clk) disable iff (sys_rst) // RULE_02
		(tx_active && !dfm_q[DFM_POL]) |=> dir_pin)
		else $error("direction pin not high while transmitting");
	chk_irq_follows_act: assert property (@(posedge clk) disable iff (sys_rst) // RULE_23
		(|ev.act) |=> irq)
		else $error("interrupt missing with enabled pending event");
	chk_lsr_on_error: assert property (@(posedge clk) disable iff (sys_rst) // RULE_12
		(rx_push && |rx_push_err) |=> ls_pend_q)
		else $error("line status not pending after errored receipt");
	chk_tx_write_clear: assert property (@(posedge clk) disable iff (sys_rst) // RULE_21
		(thr_wr && !tx_set) |=> !tx_pend_q)
		else $error("transmit ready survived holding write");
	chk_wake_hold_clear: assert property (@(posedge clk) disable iff (sys_rst) // RULE_20
		!sleep_exit |=> wake_ind == ($past(wake_ind) && !$past(sum_rd)))
		else $error("wake indication not held until summary read");
	chk_isr_read_code: assert property (@(posedge clk) disable iff (sys_rst) // RULE_22
		(isr_rd && ev.act == 7'h00 && ev.sel == SRC_NONE) |=> rd_data[0] == 1'b1)
		else $error("status bit 0 low with nothing pending");
	chk_flow_parity_drop: assert property (@(posedge clk) disable iff (sys_rst) // RULE_04
		(flow_char && flow_par_err && dfm_q[DFM_PCHK]) |=> !flow_char_ok)
		else $error("errored flow character accepted under check");
endmodule

// *** logic/uidc_pkg.sv ***
// constants, register map and helpers for the uart interrupt and divisor control block
package uidc_pkg;
	// receive and transmit fifo level width (256 entries plus full)
	localparam int LVL_W = 9;
	localparam int TMO_W = 10;

	// register addresses, on the 4-bit register port
	localparam logic [3:0] A_DATA = 4'h0;
	localparam logic [3:0] A_IEN = 4'h1;
	localparam logic [3:0] A_ISR = 4'h2;
	localparam logic [3:0] A_LFR = 4'h3;
	localparam logic [3:0] A_MCR = 4'h4;
	localparam logic [3:0] A_LSR = 4'h5;
	localparam logic [3:0] A_MSR = 4'h6;
	localparam logic [3:0] A_FEATURE_CONTROL_REG = 4'h8;
	localparam logic [3:0] A_EFR = 4'h9;
	localparam logic [3:0] A_SUM = 4'hA;

	// field positions
	localparam int LFR_DLAB = 7;
	localparam int DFM_POL = 7;
	localparam int DFM_MDROP = 6;
	localparam int DFM_PCHK = 5;
	localparam int DFM_FIR = 4;
	localparam int EFR_ACTS = 7;
	localparam int EFR_ARTS = 6;
	localparam int EFR_ENH = 4;
	localparam int MCR_PSEL = 2;
	localparam int FEATURE_CONTROL_REG_A485 = 5;
	localparam int FCR_FEN = 0;
	localparam int IEN_RX = 0;
	localparam int IEN_TX = 1;
	localparam int IEN_LS = 2;
	localparam int IEN_MS = 3;
	localparam int IEN_XOFF = 5;
	localparam int IEN_RTS = 6;
	localparam int IEN_CTS = 7;

	// reset values
	localparam logic [7:0] RST_REG = 8'h00;

	// interrupt sources, index is priority level minus one
	localparam int N_SRC = 7;
	localparam logic [2:0] SRC_LS = 3'h0;
	localparam logic [2:0] SRC_RX = 3'h1;
	localparam logic [2:0] SRC_TMO = 3'h2;
	localparam logic [2:0] SRC_TX = 3'h3;
	localparam logic [2:0] SRC_MS = 3'h4;
	localparam logic [2:0] SRC_XSP = 3'h5;
	localparam logic [2:0] SRC_FLOW = 3'h6;
	localparam logic [2:0] SRC_NONE = 3'h7;

	// status codes in interrupt status bits 5:0
	localparam logic [5:0] CODE_LS = 6'h06;
	localparam logic [5:0] CODE_RX = 6'h04;
	localparam logic [5:0] CODE_TMO = 6'h0C;
	localparam logic [5:0] CODE_TX = 6'h02;
	localparam logic [5:0] CODE_MS = 6'h00;
	localparam logic [5:0] CODE_XSP = 6'h10;
	localparam logic [5:0] CODE_FLOW = 6'h20;
	localparam logic [5:0] CODE_NONE = 6'h01;

	// infrared pulse width in sixteenths of a bit
	localparam logic [2:0] IR_W_SLOW = 3'h3;
	localparam logic [2:0] IR_W_FAST = 3'h4;

	// receive timeout: characters and extra bit times
	localparam int TMO_CHARS = 4;
	localparam int TMO_BITS = 12;
	localparam int FRAME_EXTRA = 2;
	localparam int DATA_MIN = 5;

	// map a source to its status code
	function automatic logic [5:0] src_code(input logic [2:0] s);
		case (s)
			SRC_LS: src_code = CODE_LS;
			SRC_RX: src_code = CODE_RX;
			SRC_TMO: src_code = CODE_TMO;
			SRC_TX: src_code = CODE_TX;
			SRC_MS: src_code = CODE_MS;
			SRC_XSP: src_code = CODE_XSP;
			SRC_FLOW: src_code = CODE_FLOW;
			default: src_code = CODE_NONE;
		endcase
	endfunction

	// timeout length in bit times for the word length field
	function automatic logic [TMO_W-1:0] tmo_limit(input logic [1:0] wl);
		tmo_limit = TMO_W'(TMO_CHARS * (DATA_MIN + int'(wl) + FRAME_EXTRA) + TMO_BITS);
	endfunction
endpackage

// *** logic/uidc_ev_if.sv ***
// event, priority and timeout signals shared inside the block
`timescale 1ns/100ps
interface uidc_ev_if;
	logic [6:0] act;
	logic [2:0] sel;
	logic [5:0] code;
	logic arm;
	logic tick;
	logic clr;
	logic fire;
	logic [9:0] limit;
	modport ctl(output act, arm, tick, clr, limit, input sel, code, fire);
	modport pri(input act, output sel, code);
	modport tmo(input arm, tick, clr, limit, output fire);
endinterface

// *** logic/uidc_prio.sv ***
// priority selector: holds the presented source until it is serviced
`timescale 1ns/100ps
module uidc_prio (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// sources and selection
	uidc_ev_if.pri ev
);
	import uidc_pkg::*;

	logic [2:0] sel_d;

	// keep the current source while still active, else take the highest
	always_comb begin
		sel_d = SRC_NONE;
		if (ev.sel != SRC_NONE && ev.act[ev.sel]) begin
			sel_d = ev.sel; // RULE_16
		end else begin
			for (int i = N_SRC - 1; i >= 0; i--) begin
				if (ev.act[i]) begin
					sel_d = 3'(i);
				end
			end
		end
	end

	// selection and code come from flops so a read sees a stable value
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ev.sel <= SRC_NONE;
			ev.code <= CODE_NONE;
		end else begin
			ev.sel <= sel_d;
			ev.code <= src_code(sel_d); // RULE_17
		end
	end

	chk_prio_hold_source: assert property (@(posedge clk) disable iff (sys_rst) // RULE_16
		(ev.sel != SRC_NONE && ev.act[ev.sel]) |=> ev.sel == $past(ev.sel))
		else $error("presented source changed before service");
	chk_prio_none_code: assert property (@(posedge clk) disable iff (sys_rst) // RULE_17
		(ev.act == 7'h00) |=> (ev.sel == SRC_NONE && ev.code == CODE_NONE))
		else $error("no source pending but code not none");
endmodule

// *** logic/uidc_rx_timeout.sv ***
// receive timeout: counts bit times while data waits below trigger
`timescale 1ns/100ps
module uidc_rx_timeout (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// arm, tick, clear and fire
	uidc_ev_if.tmo ev
);
	import uidc_pkg::*;

	logic [TMO_W-1:0] cnt_q;

	// count bit ticks; any receive push or read restarts the wait
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_q <= '0;
			ev.fire <= 1'b0;
		end else if (ev.clr || !ev.arm) begin
			cnt_q <= '0;
			ev.fire <= 1'b0;
		end else if (ev.tick && !ev.fire) begin
			cnt_q <= cnt_q + 1'b1;
			ev.fire <= (cnt_q + 1'b1) >= ev.limit; // RULE_18
		end
	end

	chk_tmo_clear_drop: assert property (@(posedge clk) disable iff (sys_rst) // RULE_18
		ev.clr |=> !ev.fire)
		else $error("timeout still flagged after clear");
	chk_tmo_fire_limit: assert property (@(posedge clk) disable iff (sys_rst) // RULE_18
		$rose(ev.fire) |-> cnt_q == ev.limit)
		else $error("timeout fired at wrong count");
endmodule

// *** verif/tb_uidc_top.sv ***
// self-checking bench for the uart interrupt and divisor control block
`timescale 1ns/100ps
module tb_uidc_top;
	import uidc_pkg::*;
	// timeout length for an eight bit word, in bit times
	localparam int TMO_N = TMO_CHARS * (DATA_MIN + 3 + FRAME_EXTRA) + TMO_BITS;
	logic clk, sys_rst, wr_stb, rd_stb, rx_push, rx_fifo_err, rx_pop;
	logic [3:0] addr, rx_push_err, rx_top_err, msr_delta, msr_state;
	logic [7:0] wr_data, rd_data, rx_char, div_low, d;
	logic [8:0] rx_level, rx_trig, tx_level, tx_trig;
	logic tx_shift_empty, tx_active, cts_n, dsr_n, rts_n, dtr_n, flow_char, flow_char_xoff;
	logic flow_par_err, special_char, flow_char_ok, bit_tick, sleep_exit, dir_pin;
	logic multidrop_en, force_parity_zero, irq, wake_ind;
	logic [2:0] ir_pulse_16ths;
	logic [7:0] div_high, line_format, modem_ctrl, fifo_ctrl, enh_feat, feat_ctrl, tx_data;
	logic [3:0] div_frac;
	logic tx_push;
	int errors = 0;
	int n_checks = 0;

	uidc_top DUT (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wr_data(wr_data),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .rx_level(rx_level),
		.rx_trig(rx_trig), .rx_push(rx_push), .rx_push_err(rx_push_err),
		.rx_top_err(rx_top_err), .rx_fifo_err(rx_fifo_err), .rx_char(rx_char),
		.rx_pop(rx_pop), .tx_level(tx_level), .tx_trig(tx_trig),
		.tx_shift_empty(tx_shift_empty), .tx_active(tx_active), .tx_push(tx_push),
		.tx_data(tx_data),
		.cts_n(cts_n), .dsr_n(dsr_n), .rts_n(rts_n), .dtr_n(dtr_n), .msr_delta(msr_delta),
		.msr_state(msr_state), .flow_char(flow_char), .flow_char_xoff(flow_char_xoff),
		.flow_par_err(flow_par_err), .special_char(special_char),
		.flow_char_ok(flow_char_ok), .bit_tick(bit_tick), .sleep_exit(sleep_exit),
		.div_low(div_low), .div_high(div_high), .div_frac(div_frac), .dir_pin(dir_pin),
		.multidrop_en(multidrop_en), .force_parity_zero(force_parity_zero),
		.ir_pulse_16ths(ir_pulse_16ths), .line_format(line_format),
		.modem_ctrl(modem_ctrl), .fifo_ctrl(fifo_ctrl), .enh_feat(enh_feat),
		.feat_ctrl(feat_ctrl), .irq(irq), .wake_ind(wake_ind));

	// free running 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	task automatic print_verdict;
		if (errors == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// one compare for every byte or flag result
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// register write, one strobe cycle
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wr_data <= v;
		wr_stb <= 1'b1;
		@(posedge clk);
		wr_stb <= 1'b0;
	endtask

	// register read, data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 v = rd_data;
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk) bit_tick <= 1'b1;
			@(posedge clk) bit_tick <= 1'b0;
		end
	endtask

	task automatic t_reset;
		rd(A_ISR, d);
		chk("isr after reset", 8'h01, d);
		chk("irq after reset", 8'h00, {7'h00, irq});
		chk("ir width after reset", 8'h03, {5'h00, ir_pulse_16ths});
	endtask

	task automatic t_divisor;
		tx_active <= 1'b1;
		wr(A_LFR, 8'h80);
		wr(A_DATA, 8'h3C);
		wr(A_IEN, 8'h12);
		wr(A_ISR, 8'hF5);
		rd(A_DATA, d);
		chk("divisor low", 8'h3C, d);
		rd(A_ISR, d);
		chk("divisor mode", 8'hF5, d);
		wr(A_LFR, 8'h03);
		cyc(2);
		chk("divisor low out", 8'h3C, div_low);
		chk("divisor high out", 8'h12, div_high);
		chk("divisor fraction", 8'h05, {4'h0, div_frac});
		chk("dir pin inverted", 8'h00, {7'h00, dir_pin});
		chk("multidrop", 8'h01, {7'h00, multidrop_en});
		chk("forced parity", 8'h01, {7'h00, force_parity_zero});
		chk("ir width fast", 8'h04, {5'h00, ir_pulse_16ths});
		rd(A_DATA, d);
		chk("data window", 8'h5A, d);
		chk("rx pop", 8'h01, {7'h00, rx_pop});
		rd(A_IEN, d);
		chk("enable not shadowed", 8'h00, d);
		// flow character carrying a parity error must be dropped now
		@(posedge clk) flow_char <= 1'b1;
		flow_par_err <= 1'b1;
		@(posedge clk) flow_char <= 1'b0;
		#1 chk("flow bad parity", 8'h00, {7'h00, flow_char_ok});
		@(posedge clk) flow_char <= 1'b1;
		flow_par_err <= 1'b0;
		@(posedge clk) flow_char <= 1'b0;
		#1 chk("flow good parity", 8'h01, {7'h00, flow_char_ok});
		wr(A_ISR, 8'h07);
		#1 chk("fifo ctrl pulse", 8'h07, fifo_ctrl);
		@(posedge clk);
		#1 chk("fifo ctrl settle", 8'h01, fifo_ctrl);
	endtask

	task automatic t_line;
		wr(A_IEN, 8'h04);
		@(posedge clk) rx_push <= 1'b1;
		rx_push_err <= 4'h2;
		rx_fifo_err <= 1'b1;
		@(posedge clk) rx_push <= 1'b0;
		cyc(3);
		chk("irq on errored push", 8'h01, {7'h00, irq});
		rd(A_ISR, d);
		chk("isr line code", 8'hC6, d);
		rd(A_LSR, d);
		chk("lsr deep error", 8'hE0, d);
		cyc(3);
		chk("irq after lsr read", 8'h00, {7'h00, irq});
		rx_top_err <= 4'h2;
		cyc(3);
		chk("irq error at top", 8'h01, {7'h00, irq});
		rd(A_LSR, d);
		chk("lsr top error", 8'hE4, d);
		rx_top_err <= 4'h0;
		rx_fifo_err <= 1'b0;
	endtask

	task automatic t_prio;
		wr(A_IEN, 8'h0D);
		rx_level <= 9'h004;
		rx_trig <= 9'h004;
		msr_delta <= 4'h1;
		cyc(3);
		rd(A_ISR, d);
		chk("isr rx over modem", 8'hC4, d);
		rd(A_LSR, d);
		chk("lsr data ready", 8'h61, d);
		msr_delta <= 4'h0;
		rx_level <= 9'h000;
		cyc(3);
		rd(A_ISR, d);
		chk("isr modem next", 8'hC0, d);
		rd(A_MSR, d);
		chk("msr value", 8'hA0, d);
		cyc(2);
		rd(A_ISR, d);
		chk("isr none", 8'hC1, d);
	endtask

	task automatic t_tmo;
		wr(A_IEN, 8'h01);
		rx_level <= 9'h001;
		ticks(TMO_N - 1);
		cyc(2);
		chk("no early timeout", 8'h00, {7'h00, irq});
		ticks(1);
		cyc(2);
		rd(A_ISR, d);
		chk("isr timeout", 8'hCC, d);
		rd(A_DATA, d);
		cyc(2);
		rd(A_ISR, d);
		chk("timeout cleared", 8'hC1, d);
		rx_level <= 9'h000;
	endtask

	task automatic t_flow;
		wr(A_IEN, 8'h10);
		rd(A_IEN, d);
		chk("enable bit 4", 8'h00, d);
		wr(A_EFR, 8'h10);
		wr(A_IEN, 8'h20);
		@(posedge clk) special_char <= 1'b1;
		@(posedge clk) special_char <= 1'b0;
		cyc(3);
		rd(A_ISR, d);
		chk("isr special", 8'hD0, d);
		@(posedge clk) flow_char <= 1'b1;
		flow_char_xoff <= 1'b1;
		@(posedge clk) flow_char <= 1'b0;
		flow_char_xoff <= 1'b0;
		cyc(3);
		rd(A_ISR, d);
		chk("isr xoff", 8'hD0, d);
		rd(A_ISR, d);
		chk("special cleared", 8'hC1, d);
		wr(A_IEN, 8'h80);
		cts_n <= 1'b1;
		cyc(3);
		rd(A_ISR, d);
		chk("isr flow pin", 8'hE0, d);
		rd(A_MSR, d);
		cyc(2);
		rd(A_ISR, d);
		chk("flow cleared", 8'hC1, d);
	endtask

	task automatic t_wake;
		@(posedge clk) sleep_exit <= 1'b1;
		@(posedge clk) sleep_exit <= 1'b0;
		cyc(2);
		chk("wake set", 8'h01, {7'h00, wake_ind});
		rd(A_SUM, d);
		chk("summary wake", 8'h01, d);
		cyc(1);
		chk("wake cleared", 8'h00, {7'h00, wake_ind});
	endtask

	task automatic t_tx;
		wr(A_IEN, 8'h02);
		tx_trig <= 9'h004;
		tx_level <= 9'h008;
		cyc(3);
		tx_level <= 9'h002;
		cyc(3);
		rd(A_ISR, d);
		chk("isr tx below", 8'hC2, d);
		rd(A_ISR, d);
		chk("tx read cleared", 8'hC1, d);
		wr(A_FEATURE_CONTROL_REG, 8'h20);
		tx_shift_empty <= 1'b0;
		tx_level <= 9'h000;
		wr(A_MCR, 8'h04);
		cyc(3);
		rd(A_ISR, d);
		chk("tx waits shift", 8'hC1, d);
		tx_shift_empty <= 1'b1;
		cyc(3);
		chk("irq tx empty", 8'h01, {7'h00, irq});
		wr(A_DATA, 8'h77);
		#1 chk("tx push", 8'h01, {7'h00, tx_push});
		chk("tx data", 8'h77, tx_data);
		cyc(2);
		rd(A_ISR, d);
		chk("tx write cleared", 8'hC1, d);
		chk("line format", 8'h03, line_format);
		chk("modem ctrl", 8'h04, modem_ctrl);
		chk("enh feat", 8'h10, enh_feat);
		chk("feat ctrl", 8'h20, feat_ctrl);
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		print_verdict;
	end

	// main sequence
	initial begin
		{wr_stb, rd_stb, rx_push, rx_fifo_err, tx_active, cts_n, dsr_n, rts_n, dtr_n} = '0;
		{flow_char, flow_char_xoff, flow_par_err, special_char, bit_tick, sleep_exit} = '0;
		{addr, rx_push_err, rx_top_err, msr_delta, wr_data} = '0;
		{rx_level, rx_trig, tx_level} = '0;
		tx_trig = 9'h001;
		tx_shift_empty = 1'b1;
		msr_state = 4'hA;
		rx_char = 8'h5A;
		sys_rst = 1'b1;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		t_reset;
		t_divisor;
		t_line;
		t_prio;
		t_tmo;
		t_flow;
		t_wake;
		t_tx;
		print_verdict;
	end
endmodule
